/* File: hdl/sipsc_top.sv */
// Sleep and idle power-save controller: mode sequencing, clock and regulator gating
`timescale 1ns/1ps
module sipsc_top
	import sipsc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	input  wire logic        POWER_SAVE_EXEC,
	input  wire logic        POWER_SAVE_OPERAND,
	input  wire logic        IRQ_PENDING,
	input  wire logic        RESET_EVENT,
	input  wire logic        WDT_TIMEOUT,
	input  wire logic [7:0]  EXT_CLK_USE,
	output logic             CPU_CLK_EN,
	output logic             CPU_RESUME,
	output logic             RESUME_ISR,
	output logic             IRQ_HOLD,
	output logic             SYS_CLK_EN,
	output logic             ONCHIP_OSC_EN,
	output logic [2:0]       CLK_SRC,
	output logic             CLK_MON_ACTIVE,
	output logic             LP_RC_CLK_EN,
	output logic             WDT_CLR,
	output logic             CHANGE_NOTIFY_EN,
	output logic [7:0]       PERIPH_CLK_EN,
	output logic             CORE_REG_STBY,
	output logic             FLASH_REG_STBY
);

	sipsc_state_t state_reg;
	sipsc_state_t state_next;
	logic [15:0]  rst_ctl_reg;
	logic [15:0]  clk_ctl_reg;
	logic [7:0]   pmd_reg;
	logic [7:0]   sidl_reg;
	logic [15:0]  t1ctl_reg;
	logic         tgt_idle_reg;
	logic [2:0]   src_saved_reg;
	logic         irq_seen_reg;
	logic [1:0]   wake_cnt_reg;
	logic [2:0]   cause_reg;
	logic [2:0]   cause_next;
	logic         isr_reg;
	logic [15:0]  rdata_reg;
	logic         wdt_en;
	logic         clk_mon_en;
	logic         core_keep;
	logic         flash_keep;
	logic         in_sleep;
	logic         in_idle;
	logic         in_mode;
	logic         wake_evt;
	logic         wake_done;
	logic [7:0]   stop_idle;
	logic         st_write;

	assign wdt_en     = clk_ctl_reg[WDT_EN_BIT];
	assign clk_mon_en = clk_ctl_reg[CLK_MON_EN_BIT];
	assign core_keep  = rst_ctl_reg[CORE_KEEP_BIT];
	assign flash_keep = rst_ctl_reg[FLASH_KEEP_BIT];
	assign in_sleep   = (state_reg == ST_SLEEP);
	assign in_idle    = (state_reg == ST_IDLE);
	assign in_mode    = in_sleep | in_idle;
	assign st_write   = REG_WR && (REG_ADDR == ADDR_STATUS);

	// Any enabled interrupt, reset or time-out, or one held off at entry
	assign wake_evt = IRQ_PENDING | irq_seen_reg
		| RESET_EVENT | WDT_TIMEOUT; // [R07] [R15] [R18]
	assign wake_done = (state_reg == ST_WAKE)
		&& (wake_cnt_reg == WAKE_CYC - 2'h1);

	// Timer 1 supplies the stop-in-Idle bit of peripheral 0
	assign stop_idle = {sidl_reg[7:1], t1ctl_reg[T1_SIDL_BIT]}; // [R17]

	// Register writes
	always_ff @(posedge CLK) begin
		if (RST) begin
			rst_ctl_reg <= RST_CTL_RST;
			clk_ctl_reg <= CLK_CTL_RST;
			pmd_reg     <= PMD_RST;
			sidl_reg    <= SIDL_RST;
			t1ctl_reg   <= T1CTL_RST;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				ADDR_RST_CTL: rst_ctl_reg <= REG_WDATA;
				ADDR_CLK_CTL: clk_ctl_reg <= REG_WDATA;
				ADDR_PMD:     pmd_reg <= REG_WDATA[7:0];
				ADDR_SIDL:    sidl_reg <= REG_WDATA[7:0];
				ADDR_T1CTL:   t1ctl_reg <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_reg <= 16'h0000;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				ADDR_RST_CTL: rdata_reg <= rst_ctl_reg;
				ADDR_CLK_CTL: rdata_reg <= clk_ctl_reg;
				ADDR_PMD:     rdata_reg <= {8'h00, pmd_reg};
				ADDR_SIDL:    rdata_reg <= {8'h00, sidl_reg};
				ADDR_T1CTL:   rdata_reg <= t1ctl_reg;
				ADDR_STATUS:  rdata_reg <= {5'h00, src_saved_reg,
					1'b0, cause_reg, 1'b0, state_reg};
				default:      rdata_reg <= 16'h0000;
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign REG_RDATA = rdata_reg;

	// Mode sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (POWER_SAVE_EXEC) begin
					state_next = ST_ENTER;
				end
			end
			ST_ENTER: begin
				// Operand picks the mode; nothing aborts entry
				if (tgt_idle_reg == OP_IDLE) begin // [R19]
					state_next = ST_IDLE;
				end else begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP, ST_IDLE: begin
				if (wake_evt) begin // [R07] [R15]
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wake_done) begin // [R16]
					state_next = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Operand and clock source captured at instruction execution
	always_ff @(posedge CLK) begin
		if (RST) begin
			tgt_idle_reg  <= OP_SLEEP;
			src_saved_reg <= 3'h0;
		end else if (state_reg == ST_RUN && POWER_SAVE_EXEC) begin
			tgt_idle_reg  <= POWER_SAVE_OPERAND; // [R19]
			src_saved_reg <= clk_ctl_reg[2:0]; // [R08]
		end
	end

	// Interrupt arriving during entry is remembered until the mode ends
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_seen_reg <= 1'b0;
		end else if (state_reg == ST_RUN && POWER_SAVE_EXEC) begin
			irq_seen_reg <= IRQ_PENDING; // [R18]
		end else if (state_reg == ST_ENTER) begin
			irq_seen_reg <= irq_seen_reg | IRQ_PENDING; // [R18]
		end else if (in_mode && wake_evt) begin
			irq_seen_reg <= 1'b0;
		end
	end

	// Wake delay counter
	always_ff @(posedge CLK) begin
		if (RST) begin
			wake_cnt_reg <= 2'h0;
		end else if (state_reg == ST_WAKE) begin
			wake_cnt_reg <= wake_cnt_reg + 2'h1;
		end else begin
			wake_cnt_reg <= 2'h0;
		end
	end

	// Sticky wake causes; new cause wins over write-one-to-clear
	always_comb begin
		cause_next = cause_reg;
		if (st_write) begin
			cause_next = cause_reg & ~REG_WDATA[CAUSE_WDT_BIT:CAUSE_IRQ_BIT];
		end
		if (in_mode && wake_evt) begin
			cause_next = cause_next | {WDT_TIMEOUT, RESET_EVENT,
				IRQ_PENDING | irq_seen_reg};
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cause_reg <= 3'h0;
			isr_reg   <= 1'b0;
		end else begin
			cause_reg <= cause_next;
			if (in_mode && wake_evt) begin
				isr_reg <= (IRQ_PENDING | irq_seen_reg) & ~RESET_EVENT;
			end
		end
	end

	// Core side: clock only in run, resume pulse at end of wake delay
	assign CPU_CLK_EN = (state_reg == ST_RUN); // [R11] [R16]
	assign CPU_RESUME = wake_done; // [R16]
	assign RESUME_ISR = isr_reg;
	assign IRQ_HOLD   = (state_reg == ST_ENTER); // [R18]

	// Clock sources
	assign SYS_CLK_EN    = ~in_sleep; // [R01] [R11]
	assign ONCHIP_OSC_EN = ~in_sleep
		& (CLK_SRC != SRC_EXTERNAL); // [R01]
	assign CLK_SRC       = (state_reg == ST_RUN)
		? clk_ctl_reg[2:0] : src_saved_reg; // [R08]
	assign CLK_MON_ACTIVE = clk_mon_en & ~in_sleep; // [R02]
	assign LP_RC_CLK_EN   = wdt_en | (clk_mon_en & ~in_sleep); // [R03] [R13]

	// Watchdog clear during entry: always for Idle, when enabled for Sleep
	assign WDT_CLR = (state_reg == ST_ENTER)
		& (tgt_idle_reg | wdt_en); // [R04] [R12]

	// Change detection stays armed in every mode
	assign CHANGE_NOTIFY_EN = 1'b1; // [R05]

	// Regulators standby in Sleep unless the keep bits are set
	assign CORE_REG_STBY  = in_sleep & ~core_keep; // [R09] [R10]
	assign FLASH_REG_STBY = in_sleep & ~flash_keep; // [R09] [R10]

	// Per-peripheral clock gating
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
			always_comb begin
				if (pmd_reg[gi]) begin
					PERIPH_CLK_EN[gi] = 1'b0; // [R14]
				end else if (in_sleep) begin
					PERIPH_CLK_EN[gi] = EXT_CLK_USE[gi]; // [R05] [R06]
				end else if (in_idle) begin
					PERIPH_CLK_EN[gi] = ~stop_idle[gi]; // [R11] [R17]
				end else begin
					PERIPH_CLK_EN[gi] = 1'b1;
				end
			end
		end
	endgenerate

	// Checks
	chk_sleep_clk_off: assert property (@(posedge CLK) disable iff (RST) // [R01]
		in_sleep |-> !SYS_CLK_EN && !ONCHIP_OSC_EN)
		else $error("clock running in sleep");

	chk_mon_sleep: assert property (@(posedge CLK) disable iff (RST) // [R02]
		in_sleep |-> !CLK_MON_ACTIVE)
		else $error("fail monitor active in sleep");

	chk_rc_clk_sleep: assert property (@(posedge CLK) disable iff (RST) // [R03]
		in_sleep && wdt_en |-> LP_RC_CLK_EN)
		else $error("rc clock off with watchdog");

	chk_wdt_clr_sleep: assert property (@(posedge CLK) disable iff (RST) // [R04]
		$rose(in_sleep) && wdt_en |-> $past(WDT_CLR))
		else $error("watchdog not cleared before sleep");

	chk_notify_on: assert property (@(posedge CLK) disable iff (RST) // [R05]
		in_sleep |-> CHANGE_NOTIFY_EN
		&& ((PERIPH_CLK_EN & ~pmd_reg) == (EXT_CLK_USE & ~pmd_reg)))
		else $error("external peripheral stopped");

	chk_periph_sleep: assert property (@(posedge CLK) disable iff (RST) // [R06]
		in_sleep |-> (PERIPH_CLK_EN & ~EXT_CLK_USE) == 8'h00)
		else $error("peripheral clocked in sleep");

	chk_wake_sleep: assert property (@(posedge CLK) disable iff (RST) // [R07]
		in_sleep && (IRQ_PENDING || RESET_EVENT || WDT_TIMEOUT)
		|=> state_reg == ST_WAKE)
		else $error("sleep not left");

	chk_src_restore: assert property (@(posedge CLK) disable iff (RST) // [R08]
		state_reg == ST_RUN && POWER_SAVE_EXEC
		|=> ##1 CLK_SRC == $past(clk_ctl_reg[2:0], 2))
		else $error("clock source changed");

	chk_reg_stby: assert property (@(posedge CLK) disable iff (RST) // [R09]
		in_sleep && !core_keep && !flash_keep
		|-> CORE_REG_STBY && FLASH_REG_STBY)
		else $error("regulators not in standby");

	chk_reg_keep: assert property (@(posedge CLK) disable iff (RST) // [R10]
		core_keep && flash_keep |-> !CORE_REG_STBY && !FLASH_REG_STBY)
		else $error("regulator left active");

	chk_idle_core: assert property (@(posedge CLK) disable iff (RST) // [R11]
		in_idle |-> !CPU_CLK_EN && SYS_CLK_EN)
		else $error("idle clocks wrong");

	chk_idle_wdt: assert property (@(posedge CLK) disable iff (RST) // [R12]
		$rose(in_idle) |-> $past(WDT_CLR))
		else $error("watchdog not cleared at idle");

	chk_rc_clk_idle: assert property (@(posedge CLK) disable iff (RST) // [R13]
		in_idle && (wdt_en || clk_mon_en) |-> LP_RC_CLK_EN)
		else $error("rc clock off in idle");

	chk_pmd_off: assert property (@(posedge CLK) disable iff (RST) // [R14]
		(PERIPH_CLK_EN & pmd_reg) == 8'h00)
		else $error("disabled module clocked");

	chk_wake_idle: assert property (@(posedge CLK) disable iff (RST) // [R15]
		in_idle && WDT_TIMEOUT |=> state_reg == ST_WAKE ##3 CPU_CLK_EN)
		else $error("idle not left on timeout");

	chk_wake_time: assert property (@(posedge CLK) disable iff (RST) // [R16]
		in_idle && IRQ_PENDING |=> !CPU_CLK_EN [*2] ##[0:2] CPU_CLK_EN)
		else $error("resume time out of range");

	chk_t1_sidl: assert property (@(posedge CLK) disable iff (RST) // [R17]
		in_idle && t1ctl_reg[T1_SIDL_BIT] |-> !PERIPH_CLK_EN[0])
		else $error("timer runs in idle");

	chk_irq_hold: assert property (@(posedge CLK) disable iff (RST) // [R18]
		state_reg == ST_RUN && POWER_SAVE_EXEC && IRQ_PENDING
		|=> IRQ_HOLD ##1 in_mode ##1 state_reg == ST_WAKE)
		else $error("coincident interrupt lost");

	chk_mode_decode: assert property (@(posedge CLK) disable iff (RST) // [R19]
		state_reg == ST_RUN && POWER_SAVE_EXEC
		|=> ##1 (in_idle == $past(POWER_SAVE_OPERAND, 2)) && in_mode)
		else $error("wrong mode entered");

	chk_resume_run: assert property (@(posedge CLK) disable iff (RST) // [R16]
		CPU_RESUME |=> CPU_CLK_EN)
		else $error("core clock not back after resume");

	chk_osc_external: assert property (@(posedge CLK) disable iff (RST) // [R01]
		CLK_SRC == SRC_EXTERNAL |-> !ONCHIP_OSC_EN)
		else $error("oscillator on with external source");

	chk_hold_once: assert property (@(posedge CLK) disable iff (RST) // [R18]
		IRQ_HOLD |=> !IRQ_HOLD)
		else $error("interrupt hold too long");

	chk_isr_select: assert property (@(posedge CLK) disable iff (RST) // [R16]
		in_mode && IRQ_PENDING && !RESET_EVENT |=> RESUME_ISR)
		else $error("interrupt wake not routed to service");

	chk_stop_bits: assert property (@(posedge CLK) disable iff (RST) // [R17]
		in_idle |-> (PERIPH_CLK_EN & stop_idle) == 8'h00)
		else $error("stop-in-idle peripheral clocked");

	chk_reg_awake: assert property (@(posedge CLK) disable iff (RST) // [R09]
		!in_sleep |-> !CORE_REG_STBY && !FLASH_REG_STBY)
		else $error("regulator standby outside sleep");

	chk_sys_clk_on: assert property (@(posedge CLK) disable iff (RST) // [R11]
		!in_sleep |-> SYS_CLK_EN)
		else $error("system clock off outside sleep");

endmodule // sipsc_top

/* File: hdl/sipsc_pkg.sv */
// Constants, register map and state type for the sleep and idle power-save controller
// Behaviour
// (R01) Sleep stops the system clock and any on-chip oscillator that is its source.
// (R02) Clock-fail monitor is inactive while in Sleep.
// (R03) Low-power RC clock runs in Sleep whenever the watchdog is enabled.
// (R04) Watchdog count is cleared just before Sleep when the watchdog is enabled.
// (R05) Port change detection and externally clocked peripherals keep working in Sleep.
// (R06) Peripherals needing the system clock are disabled in Sleep.
// (R07) Sleep ends on an enabled interrupt, any reset, or watchdog time-out.
// (R08) After Sleep the core resumes on the clock source chosen at entry.
// (R09) Regulator keep bits 8 and 11 clear: both regulators go standby in Sleep.
// (R10) Regulator keep bits set: both regulators stay active through Sleep.
// (R11) Idle stops the core; system clock stays on and peripherals keep running.
// (R12) Watchdog count is cleared on every Idle entry.
// (R13) Low-power RC clock runs in Idle if watchdog or clock-fail monitor enabled.
// (R14) Module-disable control stops chosen peripherals even with the clock running.
// (R15) Idle ends on an enabled interrupt, any reset, or watchdog time-out.
// (R16) Core clock returns and execution resumes 2 to 4 cycles after Idle wake.
// (R17) Each peripheral has a stop-in-Idle bit, timer 1 at control bit 13.
// (R18) Interrupt during the power-save instruction is held until entry, then wakes.
// (R19) Power-save instruction operand selects Sleep or Idle at execution.
package sipsc_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_RST_CTL = 4'h0;
	localparam logic [3:0] ADDR_CLK_CTL = 4'h1;
	localparam logic [3:0] ADDR_PMD     = 4'h2;
	localparam logic [3:0] ADDR_SIDL    = 4'h3;
	localparam logic [3:0] ADDR_T1CTL   = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h5;
	// Field positions
	localparam int CORE_KEEP_BIT  = 8;
	localparam int FLASH_KEEP_BIT = 11;
	localparam int T1_SIDL_BIT    = 13;
	localparam int WDT_EN_BIT     = 4;
	localparam int CLK_MON_EN_BIT = 5;
	localparam int CAUSE_IRQ_BIT  = 4;
	localparam int CAUSE_RST_BIT  = 5;
	localparam int CAUSE_WDT_BIT  = 6;
	// Reset values
	localparam logic [15:0] RST_CTL_RST = 16'h0000;
	localparam logic [15:0] CLK_CTL_RST = 16'h0000;
	localparam logic [7:0]  PMD_RST     = 8'h00;
	localparam logic [7:0]  SIDL_RST    = 8'h00;
	localparam logic [15:0] T1CTL_RST   = 16'h0000;
	// Clock source code that is an external, off-chip source
	localparam logic [2:0] SRC_EXTERNAL = 3'h2;
	// Power-save operand codes
	localparam logic OP_SLEEP = 1'b0;
	localparam logic OP_IDLE  = 1'b1;
	// Wake-up delay in clock cycles, inside the 2 to 4 window
	localparam int WAKE_MIN_CYC = 2;
	localparam int WAKE_MAX_CYC = 4;
	localparam logic [1:0] WAKE_CYC = 2'h3;
	localparam int NUM_PERIPH = 8;
	typedef enum logic [2:0] {
		ST_RUN,
		ST_ENTER,
		ST_SLEEP,
		ST_IDLE,
		ST_WAKE
	} sipsc_state_t;
endpackage

/* File: tb/sipsc_core_model.sv */
// Behavioural core model: issues the power-save instruction and raises interrupts
`timescale 1ns/1ps
module sipsc_core_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic go,
	input  wire logic op,
	input  wire logic irq_go,
	input  wire logic cpu_clk_en,
	input  wire logic cpu_resume,
	output logic      exec,
	output logic      operand,
	output logic      irq_pending
);
	// Instruction issues only while the core is clocked
	assign exec = go & cpu_clk_en;
	// Operand is junk outside the executing cycle
	assign operand = exec ? op : ~op;
	// Interrupt flag holds until the core resumes into service
	always_ff @(posedge clk) begin
		if (rst)
			irq_pending <= 1'b0;
		else if (irq_go)
			irq_pending <= 1'b1;
		else if (cpu_resume)
			irq_pending <= 1'b0;
	end
endmodule // sipsc_core_model

/* File: tb/tb_sleep_idle_power_save_control.sv */
// Self-checking bench for the sleep and idle power-save controller
`timescale 1ns/1ps
module tb_sleep_idle_power_save_control
	import sipsc_pkg::*;
;
	logic        clk, rst, reg_wr, reg_rd, go, opsel, irq_go, rst_ev, wdt_to;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic        exec, operand, irq_pending, cpu_clk_en, cpu_resume, resume_isr, irq_hold;
	logic        sys_clk_en, osc_en, clk_mon_act, rc_clk_en, wdt_clr, cn_en, core_stby, flash_stby;
	logic [2:0]  clk_src;
	logic [7:0]  periph_en, ext_use;
	int          err_total, compares, cyc, k;

	sipsc_top i_sipsc_top (
		.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .POWER_SAVE_EXEC(exec), .POWER_SAVE_OPERAND(operand),
		.IRQ_PENDING(irq_pending), .RESET_EVENT(rst_ev), .WDT_TIMEOUT(wdt_to), .EXT_CLK_USE(ext_use),
		.CPU_CLK_EN(cpu_clk_en), .CPU_RESUME(cpu_resume), .RESUME_ISR(resume_isr), .IRQ_HOLD(irq_hold),
		.SYS_CLK_EN(sys_clk_en), .ONCHIP_OSC_EN(osc_en), .CLK_SRC(clk_src), .CLK_MON_ACTIVE(clk_mon_act),
		.LP_RC_CLK_EN(rc_clk_en), .WDT_CLR(wdt_clr), .CHANGE_NOTIFY_EN(cn_en), .PERIPH_CLK_EN(periph_en),
		.CORE_REG_STBY(core_stby), .FLASH_REG_STBY(flash_stby)
	);
	sipsc_core_model i_sipsc_core_model (
		.clk(clk), .rst(rst), .go(go), .op(opsel), .irq_go(irq_go), .cpu_clk_en(cpu_clk_en),
		.cpu_resume(cpu_resume), .exec(exec), .operand(operand), .irq_pending(irq_pending)
	);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	task automatic tally_and_finish;
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Cut a hung run short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk1(input logic seen, input logic exp);
		check({15'h0, seen}, {15'h0, exp});
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Power-save instruction, optionally with a coincident interrupt; returns in the entry cycle
	task automatic enter(input logic op, input logic irq);
		@(posedge clk);
		go <= 1'b1;
		opsel <= op;
		irq_go <= irq;
		@(posedge clk);
		go <= 1'b0;
		irq_go <= 1'b0;
		#1;
	endtask

	// Wake event 0 interrupt, 1 reset, 2 watchdog; counts cycles until the core clock returns
	task automatic wake(input logic [1:0] src, input logic isr);
		k = (src == 2'h0) ? 0 : 1;
		@(posedge clk);
		irq_go <= (src == 2'h0);
		rst_ev <= (src == 2'h1);
		wdt_to <= (src == 2'h2);
		@(posedge clk);
		irq_go <= 1'b0;
		rst_ev <= 1'b0;
		wdt_to <= 1'b0;
		#1;
		while (cpu_clk_en !== 1'b1 && k < 9) begin
			@(posedge clk);
			#1;
			k++;
			chk1(cpu_resume, k == 3);
		end
		check(16'(k), 16'h0004);
		chk1(resume_isr, isr);
	endtask

	task automatic step;
		@(posedge clk);
		#1;
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, go, opsel, irq_go, rst_ev, wdt_to} = '0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		ext_use = 8'h30;
		err_total = 0;
		compares = 0;
		cyc = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped write ignored
		wr(4'hf, 16'hffff);
		for (int a = 0; a < 6; a++)
			rd(4'(a), 16'h0000);
		rd(4'hf, 16'h0000);
		check({8'h0, periph_en}, 16'h00ff);
		chk1(cpu_clk_en, 1'b1);
		// Idle with watchdog, woken by interrupt
		wr(ADDR_CLK_CTL, 16'h0010);
		enter(OP_IDLE, 1'b0);
		chk1(irq_hold, 1'b1);
		chk1(wdt_clr, 1'b1);
		step();
		chk1(cpu_clk_en, 1'b0);
		chk1(sys_clk_en, 1'b1);
		chk1(rc_clk_en, 1'b1);
		check({8'h0, periph_en}, 16'h00ff);
		rd(ADDR_STATUS, 16'h0003);
		wake(2'h0, 1'b1);
		rd(ADDR_STATUS, 16'h0010);
		wr(ADDR_STATUS, 16'h0070);
		rd(ADDR_STATUS, 16'h0000);
		// Sleep on external source, watchdog off, woken by watchdog
		wr(ADDR_CLK_CTL, 16'h0022);
		enter(OP_SLEEP, 1'b0);
		chk1(wdt_clr, 1'b0);
		step();
		chk1(sys_clk_en, 1'b0);
		chk1(osc_en, 1'b0);
		chk1(clk_mon_act, 1'b0);
		chk1(rc_clk_en, 1'b0);
		chk1(core_stby, 1'b1);
		chk1(flash_stby, 1'b1);
		chk1(cn_en, 1'b1);
		check({8'h0, periph_en}, 16'h0030);
		rd(ADDR_STATUS, 16'h0202);
		wake(2'h2, 1'b0);
		check({13'h0, clk_src}, 16'h0002);
		chk1(osc_en, 1'b0);
		chk1(clk_mon_act, 1'b1);
		rd(ADDR_STATUS, 16'h0240);
		// Sleep with regulators kept, watchdog on, woken by reset
		wr(ADDR_RST_CTL, 16'h0900);
		wr(ADDR_CLK_CTL, 16'h0031);
		enter(OP_SLEEP, 1'b0);
		chk1(wdt_clr, 1'b1);
		step();
		chk1(core_stby, 1'b0);
		chk1(flash_stby, 1'b0);
		chk1(rc_clk_en, 1'b1);
		chk1(osc_en, 1'b0);
		wake(2'h1, 1'b0);
		check({13'h0, clk_src}, 16'h0001);
		chk1(osc_en, 1'b1);
		// Causes are sticky: the watchdog cause of the previous wake is still set beside the reset cause
		rd(ADDR_STATUS, 16'h0160);
		wr(ADDR_RST_CTL, 16'h0000);
		// Idle with module disable and stop-in-idle bits
		wr(ADDR_CLK_CTL, 16'h0020);
		wr(ADDR_PMD, 16'h0004);
		wr(ADDR_SIDL, 16'h0010);
		wr(ADDR_T1CTL, 16'h2000);
		check({8'h0, periph_en}, 16'h00fb);
		enter(OP_IDLE, 1'b0);
		chk1(wdt_clr, 1'b1);
		step();
		check({8'h0, periph_en}, 16'h00ea);
		chk1(rc_clk_en, 1'b1);
		wake(2'h2, 1'b0);
		// Interrupt already pending as the instruction executes: entry completes, then wakes
		@(posedge clk);
		irq_go <= 1'b1;
		enter(OP_SLEEP, 1'b1);
		chk1(irq_hold, 1'b1);
		step();
		chk1(sys_clk_en, 1'b0);
		k = 0;
		while (cpu_clk_en !== 1'b1 && k < 9) begin
			step();
			k++;
			chk1(cpu_resume, k == 3);
		end
		check(16'(k), 16'h0004);
		chk1(resume_isr, 1'b1);
		rd(ADDR_STATUS, 16'h0070);
		tally_and_finish();
	end
endmodule // tb_sleep_idle_power_save_control
